// *** uetc_params.svh ***
// Register offsets, field positions and codes for the endpoint type block
`ifndef UETC_PARAMS_SVH
`define UETC_PARAMS_SVH

`define UETC_OFF_MAXPKT 8'h04
`define UETC_OFF_TYPE 8'h08
`define UETC_OFF_STATUS 8'h10
`define UETC_OFF_INDEX 8'h2C

`define UETC_TYP_MSB 1
`define UETC_DBL_BIT 2
`define UETC_EN_BIT 3
`define UETC_NOZLP_BIT 4
`define UETC_TYPE_W 5
`define UETC_SIZE_W 11
`define UETC_MPS_W 13

`define UETC_ALLOC_W 12
`define UETC_RESP_OKAY 2'h0
`define UETC_RESP_SLVERR 2'h2

`endif

// *** uetc_pkg.sv ***
// Types shared by the endpoint type block
`default_nettype none
package uetc_pkg;

	typedef enum logic [1:0] {
		XFER_UNUSED = 2'h0,
		XFER_ISO = 2'h1,
		XFER_BULK = 2'h2,
		XFER_INTR = 2'h3
	} uetc_xfer_type;

	typedef enum logic [1:0] {
		RD_IDLE = 2'h0,
		RD_WAIT = 2'h1,
		RD_RESP = 2'h2
	} uetc_rd_state_type;

endpackage

`default_nettype wire

// *** uetc_cfg_mem.sv ***
// Per-endpoint storage with one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none

module uetc_cfg_mem #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 5,
	parameter int AW = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clear,
	// Write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// Read ports
	input wire logic [AW-1:0] a_addr,
	output logic [WIDTH-1:0] a_data,
	input wire logic [AW-1:0] b_addr,
	output logic [WIDTH-1:0] b_data
);

	logic [WIDTH-1:0] mem_reg [DEPTH];

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
		end else if (clear) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
		end else if (wr_en) begin
			mem_reg[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			a_data <= '0;
			b_data <= '0;
		end else begin
			a_data <= mem_reg[a_addr];
			b_data <= mem_reg[b_addr];
		end
	end

endmodule

`default_nettype wire

// *** uetc_ep_config.sv ***
// Endpoint type configuration registers with AXI4-Lite access
//
// How it works
// - 16-bit config register at 08h, per indexed endpoint
// - Bits 1:0 encode unused, iso, bulk, interrupt
// - Bit 3 enables or disables endpoint FIFO
// - Enabled endpoint gets buffer sized by max-packet
// - Bit 2 selects double or single buffering
// - Bit 4 low sends zero-length packet after DMA
// - Stall keeps data toggle unchanged
// - Eleven-bit size field sets FIFO bytes
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "uetc_params.svh"

module uetc_ep_config #(
	parameter int NUM_EP = 8,
	parameter int EP_AW = 3,
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// AXI4-Lite write
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// USB engine events
	input wire logic usb_bus_reset,
	input wire logic [NUM_EP-1:0] ep_stalled,
	input wire logic toggle_advance,
	input wire logic [EP_AW-1:0] toggle_ep,
	input wire logic dma_in_done,
	input wire logic [EP_AW-1:0] dma_ep,
	input wire logic in_token,
	input wire logic [EP_AW-1:0] in_ep,
	// Endpoint state
	output logic [NUM_EP-1:0] ep_fifo_active,
	output logic [NUM_EP-1:0] ep_double_buffer,
	output logic [NUM_EP-1:0] data_toggle,
	output logic zlp_send,
	output logic [EP_AW-1:0] zlp_ep,
	// Config lookup
	input wire logic [EP_AW-1:0] query_ep,
	output uetc_pkg::uetc_xfer_type query_type,
	output logic [`UETC_ALLOC_W-1:0] query_alloc
);

	localparam logic [2:0] SEL_NONE = 3'h0;
	localparam logic [2:0] SEL_INDEX = 3'h1;
	localparam logic [2:0] SEL_MPS = 3'h2;
	localparam logic [2:0] SEL_TYPE = 3'h3;
	localparam logic [2:0] SEL_STATUS = 3'h4;

	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] addr);
		logic [7:0] a;
		a = 8'(addr);
		if (a == `UETC_OFF_INDEX) return SEL_INDEX;
		if (a == `UETC_OFF_MAXPKT) return SEL_MPS;
		if (a == `UETC_OFF_TYPE) return SEL_TYPE;
		if (a == `UETC_OFF_STATUS) return SEL_STATUS;
		return SEL_NONE;
	endfunction

	// Buffer bytes taken by one endpoint
	function automatic logic [`UETC_ALLOC_W-1:0] alloc_bytes(input logic [`UETC_SIZE_W-1:0] size, input logic dbl);
		return dbl ? {size, 1'b0} : {1'b0, size};
	endfunction

	logic aw_have_reg, w_have_reg, awready_reg, wready_reg, bvalid_reg;
	logic [ADDR_W-1:0] awaddr_reg, araddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic [1:0] bresp_reg;
	logic arready_reg, rvalid_reg;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	uetc_pkg::uetc_rd_state_type rd_state_reg;
	logic [EP_AW-1:0] index_reg;
	logic [NUM_EP-1:0] ep_enable_reg, ep_double_reg, ep_nozlp_reg, data_toggle_reg, zlp_pending_reg;
	logic zlp_send_reg;
	logic [EP_AW-1:0] zlp_ep_reg;
	logic [1:0] query_type_reg;
	logic [`UETC_ALLOC_W-1:0] query_alloc_reg;
	logic [`UETC_TYPE_W-1:0] type_a, type_b, type_new;
	logic [`UETC_MPS_W-1:0] mps_a, mps_b, mps_new;
	logic commit, type_we, mps_we, en_old, en_new;
	logic [2:0] wsel;

	assign commit = aw_have_reg && w_have_reg && !bvalid_reg;
	assign wsel = reg_sel(awaddr_reg);
	assign type_we = commit && (wsel == SEL_TYPE);
	assign mps_we = commit && (wsel == SEL_MPS);
	// Reserved bits above the defined fields are dropped
	assign type_new = wstrb_reg[0] ? wdata_reg[`UETC_TYPE_W-1:0] : type_a;
	assign mps_new = {wstrb_reg[1] ? wdata_reg[12:8] : mps_a[12:8], wstrb_reg[0] ? wdata_reg[7:0] : mps_a[7:0]};
	assign en_old = ep_enable_reg[index_reg];
	assign en_new = type_new[`UETC_EN_BIT];

	// Port A follows the index, port B serves the USB engine
	uetc_cfg_mem #(.DEPTH(NUM_EP), .WIDTH(`UETC_TYPE_W), .AW(EP_AW)) type_mem (
		.clk(clk),
		.reset_n(reset_n),
		.clear(usb_bus_reset),
		.wr_en(type_we),
		.wr_addr(index_reg),
		.wr_data(type_new),
		.a_addr(index_reg),
		.a_data(type_a),
		.b_addr(query_ep),
		.b_data(type_b)
	);

	uetc_cfg_mem #(.DEPTH(NUM_EP), .WIDTH(`UETC_MPS_W), .AW(EP_AW)) mps_mem (
		.clk(clk),
		.reset_n(reset_n),
		.clear(usb_bus_reset),
		.wr_en(mps_we),
		.wr_addr(index_reg),
		.wr_data(mps_new),
		.a_addr(index_reg),
		.a_data(mps_a),
		.b_addr(query_ep),
		.b_data(mps_b)
	);

	// Write channel
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `UETC_RESP_OKAY;
			awaddr_reg <= '0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid && awready_reg) begin
				aw_have_reg <= 1'b1;
				awready_reg <= 1'b0;
				awaddr_reg <= s_axi_awaddr;
			end else if (!aw_have_reg && !bvalid_reg) begin
				awready_reg <= 1'b1;
			end
			if (s_axi_wvalid && wready_reg) begin
				w_have_reg <= 1'b1;
				wready_reg <= 1'b0;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end else if (!w_have_reg && !bvalid_reg) begin
				wready_reg <= 1'b1;
			end
			if (commit) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= (wsel == SEL_NONE) ? `UETC_RESP_SLVERR : `UETC_RESP_OKAY;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			index_reg <= '0;
		end else if (commit && wsel == SEL_INDEX && wstrb_reg[0]) begin
			index_reg <= wdata_reg[EP_AW-1:0];
		end
	end

	// Read data selection
	always_comb begin
		rdata_next = 32'h0000_0000;
		rresp_next = `UETC_RESP_OKAY;
		case (reg_sel(araddr_reg))
			SEL_INDEX: rdata_next = 32'(index_reg);
			SEL_MPS: rdata_next = 32'(mps_a);
			SEL_TYPE: rdata_next = 32'(type_a);
			SEL_STATUS: rdata_next = {4'h0, alloc_bytes(mps_a[`UETC_SIZE_W-1:0], type_a[`UETC_DBL_BIT]),
				14'h0000, zlp_pending_reg[index_reg], data_toggle_reg[index_reg]};
			default: rresp_next = `UETC_RESP_SLVERR;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_state_reg <= uetc_pkg::RD_IDLE;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			araddr_reg <= '0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `UETC_RESP_OKAY;
		end else begin
			case (rd_state_reg)
				uetc_pkg::RD_IDLE: begin
					if (s_axi_arvalid && arready_reg) begin
						araddr_reg <= s_axi_araddr;
						arready_reg <= 1'b0;
						rd_state_reg <= uetc_pkg::RD_WAIT;
					end else begin
						arready_reg <= 1'b1;
					end
				end
				uetc_pkg::RD_WAIT: begin
					rdata_reg <= rdata_next;
					rresp_reg <= rresp_next;
					rvalid_reg <= 1'b1;
					rd_state_reg <= uetc_pkg::RD_RESP;
				end
				uetc_pkg::RD_RESP: begin
					if (s_axi_rready) begin
						rvalid_reg <= 1'b0;
						rd_state_reg <= uetc_pkg::RD_IDLE;
					end
				end
				default: begin
					rvalid_reg <= 1'b0;
					rd_state_reg <= uetc_pkg::RD_IDLE;
				end
			endcase
		end
	end

	// Per-endpoint mirrors of enable, double buffer and zero-length choice
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ep_enable_reg <= '0;
			ep_double_reg <= '0;
			ep_nozlp_reg <= '0;
		end else if (usb_bus_reset) begin
			ep_enable_reg <= '0;
			ep_double_reg <= '0;
			ep_nozlp_reg <= '0;
		end else if (type_we) begin
			ep_enable_reg[index_reg] <= en_new;
			ep_double_reg[index_reg] <= type_new[`UETC_DBL_BIT];
			ep_nozlp_reg[index_reg] <= type_new[`UETC_NOZLP_BIT];
		end
	end

	// Data toggle per endpoint
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			data_toggle_reg <= '0;
		end else if (usb_bus_reset) begin
			data_toggle_reg <= '0;
		end else begin
			if (toggle_advance && ep_enable_reg[toggle_ep] && !ep_stalled[toggle_ep]) begin
				data_toggle_reg[toggle_ep] <= !data_toggle_reg[toggle_ep];
			end
			if (type_we && en_old != en_new) begin
				data_toggle_reg[index_reg] <= 1'b0;
			end
		end
	end

	// Zero-length packet owed after a DMA IN transfer; a new set beats a clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			zlp_pending_reg <= '0;
			zlp_send_reg <= 1'b0;
			zlp_ep_reg <= '0;
		end else if (usb_bus_reset) begin
			zlp_pending_reg <= '0;
			zlp_send_reg <= 1'b0;
		end else begin
			zlp_send_reg <= in_token && zlp_pending_reg[in_ep];
			zlp_ep_reg <= in_ep;
			if (in_token && zlp_pending_reg[in_ep]) begin
				zlp_pending_reg[in_ep] <= 1'b0;
			end
			if (dma_in_done && ep_enable_reg[dma_ep] && !ep_nozlp_reg[dma_ep]) begin
				zlp_pending_reg[dma_ep] <= 1'b1;
			end
		end
	end

	// Lookup for the USB engine, two cycles after query_ep
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			query_type_reg <= 2'h0;
			query_alloc_reg <= '0;
		end else begin
			query_type_reg <= type_b[`UETC_TYP_MSB:0];
			query_alloc_reg <= type_b[`UETC_EN_BIT] ?
				alloc_bytes(mps_b[`UETC_SIZE_W-1:0], type_b[`UETC_DBL_BIT]) : '0;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign ep_fifo_active = ep_enable_reg;
	assign ep_double_buffer = ep_double_reg;
	assign data_toggle = data_toggle_reg;
	assign zlp_send = zlp_send_reg;
	assign zlp_ep = zlp_ep_reg;
	assign query_type = uetc_pkg::uetc_xfer_type'(query_type_reg);
	assign query_alloc = query_alloc_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	write_resp_a: assert property (commit |=> s_axi_bvalid)
		else $error("write response missing");
	read_latency_a: assert property ((s_axi_arvalid && s_axi_arready) |-> ##2 s_axi_rvalid)
		else $error("read data not two cycles after address");
	enable_mirror_a: assert property ((type_we && !usb_bus_reset) |=> ep_enable_reg[$past(index_reg)] == $past(en_new))
		else $error("enable bit not applied");
	double_mirror_a: assert property ((type_we && !usb_bus_reset) |=>
		ep_double_reg[$past(index_reg)] == $past(type_new[`UETC_DBL_BIT]))
		else $error("double buffer bit not applied");
	toggle_stall_a: assert property ((toggle_advance && ep_stalled[toggle_ep] &&
		!type_we && !usb_bus_reset) |=> $stable(data_toggle_reg))
		else $error("toggle moved while stalled");
	toggle_reset_a: assert property ((type_we && en_old != en_new && !usb_bus_reset) |=>
		!data_toggle_reg[$past(index_reg)])
		else $error("toggle not reset on enable change");
	zlp_set_a: assert property ((dma_in_done && ep_enable_reg[dma_ep] &&
		!ep_nozlp_reg[dma_ep] && !usb_bus_reset) |=> zlp_pending_reg[$past(dma_ep)])
		else $error("zero-length packet not queued");
	zlp_suppress_a: assert property ((dma_in_done && ep_nozlp_reg[dma_ep] &&
		!zlp_pending_reg[dma_ep]) |=> !zlp_pending_reg[$past(dma_ep)])
		else $error("zero-length packet queued while suppressed");
	zlp_send_a: assert property ((in_token && zlp_pending_reg[in_ep] && !usb_bus_reset) |=>
		zlp_send && zlp_ep == $past(in_ep))
		else $error("zero-length packet not sent");
	bus_reset_a: assert property (usb_bus_reset |=> ep_enable_reg == '0 && data_toggle_reg == '0 && ep_nozlp_reg == '0)
		else $error("bus reset left state");

endmodule

`default_nettype wire

// *** uetc_usb_model.sv ***
// USB engine event source facing the endpoint config block
`timescale 1ns/1ps
`default_nettype none

module uetc_usb_model #(
	parameter int NUM_EP = 8,
	parameter int EP_AW = 3
) (
	// Clock
	input wire logic clk,
	// Engine events
	output logic usb_bus_reset,
	output logic [NUM_EP-1:0] ep_stalled,
	output logic toggle_advance,
	output logic dma_in_done,
	output logic in_token,
	output logic [EP_AW-1:0] event_ep
);
	initial begin
		usb_bus_reset = 1'b0;
		ep_stalled = '0;
		toggle_advance = 1'b0;
		dma_in_done = 1'b0;
		in_token = 1'b0;
		event_ep = '0;
	end

	// Kind 0 toggle, 1 dma done, 2 in token, 3 bus reset
	task automatic pulse(input int kind, input logic [EP_AW-1:0] ep);
		@(posedge clk);
		event_ep <= ep;
		toggle_advance <= (kind == 0);
		dma_in_done <= (kind == 1);
		in_token <= (kind == 2);
		usb_bus_reset <= (kind == 3);
		@(posedge clk);
		// Idle endpoint lines show no stale value
		event_ep <= ~ep;
		toggle_advance <= 1'b0;
		dma_in_done <= 1'b0;
		in_token <= 1'b0;
		usb_bus_reset <= 1'b0;
	endtask

	task automatic stall(input logic [EP_AW-1:0] ep, input logic on);
		@(posedge clk);
		ep_stalled[ep] <= on;
	endtask
endmodule
`default_nettype wire

// *** tb_usb_endpoint_type_config.sv ***
// Self-checking bench for the endpoint type config block
`timescale 1ns/1ps
`default_nettype none
`include "uetc_params.svh"

module tb_usb_endpoint_type_config;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hF;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, zlp_send, usb_bus_reset, toggle_advance, dma_in_done, in_token;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] ep_stalled, ep_fifo_active, ep_double_buffer, data_toggle;
	logic [2:0] event_ep, zlp_ep;
	logic [2:0] zlp_last = 3'h0;
	logic [31:0] zlp_count = 32'h0000_0000;
	uetc_pkg::uetc_xfer_type query_type;
	logic [11:0] query_alloc;
	int err_count = 0;
	int tests_run = 0;

	always #12.5 clk = ~clk;

	uetc_ep_config dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .usb_bus_reset(usb_bus_reset),
		.ep_stalled(ep_stalled), .toggle_advance(toggle_advance), .toggle_ep(event_ep),
		.dma_in_done(dma_in_done), .dma_ep(event_ep), .in_token(in_token), .in_ep(event_ep),
		.ep_fifo_active(ep_fifo_active), .ep_double_buffer(ep_double_buffer), .data_toggle(data_toggle),
		.zlp_send(zlp_send), .zlp_ep(zlp_ep), .query_ep(3'h3), .query_type(query_type),
		.query_alloc(query_alloc));

	uetc_usb_model usb (.clk(clk), .usb_bus_reset(usb_bus_reset), .ep_stalled(ep_stalled),
		.toggle_advance(toggle_advance), .dma_in_done(dma_in_done), .in_token(in_token), .event_ep(event_ep));

	// Zero-length packet pulses last one cycle
	always @(posedge clk) begin
		if (zlp_send === 1'b1) begin
			zlp_count <= zlp_count + 32'h0000_0001;
			zlp_last <= zlp_ep;
		end
	end

	task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_flag(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic axi_write(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] resp);
		bit aw_done;
		bit w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk);
		awaddr <= addr;
		awvalid <= 1'b1;
		wdata <= data;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		check_data({30'h0, bresp}, {30'h0, resp});
	endtask

	task automatic axi_read(input logic [7:0] addr, input logic [31:0] exp, input logic [1:0] resp);
		@(posedge clk);
		araddr <= addr;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		check_data(rdata, exp);
		check_data({30'h0, rresp}, {30'h0, resp});
	endtask

	task automatic settle();
		repeat (3) @(posedge clk);
	endtask

	task automatic report_and_stop();
		if (err_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		report_and_stop();
	end

	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		axi_read(`UETC_OFF_TYPE, 32'h0000_0000, `UETC_RESP_OKAY);
		axi_write(`UETC_OFF_INDEX, 32'h0000_0003, `UETC_RESP_OKAY);
		axi_write(`UETC_OFF_MAXPKT, 32'h0000_0040, `UETC_RESP_OKAY);
		axi_read(`UETC_OFF_MAXPKT, 32'h0000_0040, `UETC_RESP_OKAY);
		// Every type code, reserved bits written high
		for (int t = 0; t < 4; t++) begin
			axi_write(`UETC_OFF_TYPE, 32'h0000_FFE8 | 32'(t), `UETC_RESP_OKAY);
			axi_read(`UETC_OFF_TYPE, 32'h0000_0008 | 32'(t), `UETC_RESP_OKAY);
			settle();
			check_data({30'h0, query_type}, 32'(t));
		end
		check_data({20'h0, query_alloc}, 32'h0000_0040);
		check_flag(ep_fifo_active[3], 1'b1);
		axi_write(`UETC_OFF_TYPE, 32'h0000_000E, `UETC_RESP_OKAY);
		settle();
		check_flag(ep_double_buffer[3], 1'b1);
		check_data({20'h0, query_alloc}, 32'h0000_0080);
		axi_write(`UETC_OFF_INDEX, 32'h0000_0005, `UETC_RESP_OKAY);
		axi_read(`UETC_OFF_TYPE, 32'h0000_0000, `UETC_RESP_OKAY);
		axi_write(`UETC_OFF_INDEX, 32'h0000_0003, `UETC_RESP_OKAY);
		axi_read(`UETC_OFF_TYPE, 32'h0000_000E, `UETC_RESP_OKAY);
		usb.pulse(0, 3'h3);
		settle();
		check_flag(data_toggle[3], 1'b1);
		axi_read(`UETC_OFF_STATUS, 32'h0080_0001, `UETC_RESP_OKAY);
		usb.stall(3'h3, 1'b1);
		usb.pulse(0, 3'h3);
		usb.stall(3'h3, 1'b0);
		settle();
		check_flag(data_toggle[3], 1'b1);
		// Disable then re-enable; each enable change clears the toggle to zero
		axi_write(`UETC_OFF_TYPE, 32'h0000_0006, `UETC_RESP_OKAY);
		settle();
		check_flag(ep_fifo_active[3], 1'b0);
		check_flag(data_toggle[3], 1'b0);
		check_data({20'h0, query_alloc}, 32'h0000_0000);
		axi_write(`UETC_OFF_TYPE, 32'h0000_000E, `UETC_RESP_OKAY);
		settle();
		check_flag(data_toggle[3], 1'b0);
		usb.pulse(1, 3'h3);
		axi_read(`UETC_OFF_STATUS, 32'h0080_0002, `UETC_RESP_OKAY);
		usb.pulse(2, 3'h3);
		settle();
		check_data(zlp_count, 32'h0000_0001);
		check_data({29'h0, zlp_last}, 32'h0000_0003);
		axi_write(`UETC_OFF_TYPE, 32'h0000_001E, `UETC_RESP_OKAY);
		usb.pulse(1, 3'h3);
		usb.pulse(2, 3'h3);
		settle();
		check_data(zlp_count, 32'h0000_0001);
		usb.pulse(3, 3'h3);
		settle();
		check_flag(ep_fifo_active[3], 1'b0);
		axi_read(`UETC_OFF_TYPE, 32'h0000_0000, `UETC_RESP_OKAY);
		axi_read(`UETC_OFF_MAXPKT, 32'h0000_0000, `UETC_RESP_OKAY);
		// Only the upper byte lane reaches the size field
		wstrb <= 4'h2;
		axi_write(`UETC_OFF_MAXPKT, 32'h0000_01FF, `UETC_RESP_OKAY);
		wstrb <= 4'hF;
		axi_read(`UETC_OFF_MAXPKT, 32'h0000_0100, `UETC_RESP_OKAY);
		axi_write(8'h40, 32'h0000_1234, `UETC_RESP_SLVERR);
		axi_read(8'h40, 32'h0000_0000, `UETC_RESP_SLVERR);
		report_and_stop();
	end
endmodule
`default_nettype wire
